/* File: ssr_ram_board.sv */
// Decode, control and storage of the switch-selected 8 KB RAM board.
// Assumes a multiplexed-address bus master; strobes arrive asynchronously on pins.
`timescale 1ns/10ps
module ssr_ram_board (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] addr_bus,
  input  wire logic       address_strobe_pulse,
  input  wire logic       memory_read_strobe_n,
  input  wire logic       memory_write_strobe_n,
  input  wire logic       run_utility_request,
  input  wire logic       option_link_set,
  input  wire logic [2:0] block_switch_closed,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            board_selected
);
  localparam int AW = ssr_pkg::ADDR_W;
  localparam int NW = ssr_pkg::NIB_W;

  typedef enum logic [1:0] {SSR_IDLE, SSR_STROBE, SSR_ACCESS} ssr_state_t;

  typedef struct packed {
    ssr_state_t  st;
    logic [7:0]  hi;      // Latched high address byte
    logic        wr_d;    // Previous write strobe level
    logic [7:0]  dout;
  } ssr_board_t;

  ssr_board_t s;
  ssr_board_t next_s;

  // Synchronised pins
  logic       tpa_s;
  logic       rd_s;
  logic       wr_s;
  logic       rnu_s;
  logic [7:0] lo_s;
  logic [7:0] din_s;

  ssr_sync u_tpa (.clk(clk), .resetn(resetn), .pin(address_strobe_pulse), .level(tpa_s));
  ssr_sync u_rd  (.clk(clk), .resetn(resetn), .pin(!memory_read_strobe_n), .level(rd_s));
  ssr_sync u_wr  (.clk(clk), .resetn(resetn), .pin(!memory_write_strobe_n), .level(wr_s));
  ssr_sync u_rnu (.clk(clk), .resetn(resetn), .pin(run_utility_request), .level(rnu_s));

  // Per-bit synchronisers for address and data lines
  genvar g;
  generate
    for (g = 0; g < AW; g++) begin : g_bus
      ssr_sync u_a (.clk(clk), .resetn(resetn), .pin(addr_bus[g]), .level(lo_s[g]));
      ssr_sync u_d (.clk(clk), .resetn(resetn), .pin(data_in[g]), .level(din_s[g]));
    end
  endgenerate

  // Eight pairs of 1024x4 devices, upper and lower nibble arrays
  logic [NW-1:0] mem_hi [ssr_pkg::PAIRS*ssr_pkg::WORDS];
  logic [NW-1:0] mem_lo [ssr_pkg::PAIRS*ssr_pkg::WORDS];

  logic       match;
  logic       enable;
  logic [2:0] pair_sel;
  logic [9:0] word_sel;
  logic [12:0] index;
  logic       wr_commit;

  // block compare, closed rocker is one, rocker 1 the LSB
  assign match = (s.hi[7:ssr_pkg::BLK_LSB] == block_switch_closed);
  // run-utility inhibit; same compare applies on the monitor connector
  assign enable = match && !(option_link_set && rnu_s);
  // pair select from A12..A10; half from bit 4, enables from bits 3..2
  assign pair_sel = {s.hi[ssr_pkg::HALF_BIT], s.hi[ssr_pkg::PAIR_LSB +: 2]};
  // bits 1..0 become device A8/A9, low byte used directly
  assign word_sel = {s.hi[ssr_pkg::ROW_LSB +: 2], lo_s};
  assign index    = {pair_sel, word_sel};

  // Access sequencing
  always_comb begin
    next_s      = s;
    next_s.wr_d = wr_s;
    case (s.st)
      SSR_IDLE: begin
        if (tpa_s) begin
          next_s.st = SSR_STROBE;
        end
      end
      SSR_STROBE: begin
        // track high byte only while strobe stands; the low byte
        // arrives in the same cycle the synchronised strobe falls
        if (tpa_s) begin
          next_s.hi = lo_s;
        end else begin
          next_s.st = SSR_ACCESS;
        end
      end
      SSR_ACCESS: begin
        if (tpa_s) begin
          next_s.st = SSR_STROBE;
        end
        if (enable && rd_s) begin
          next_s.dout = {mem_hi[index], mem_lo[index]};
        end
      end
      default: begin
        next_s.st = SSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{st: SSR_IDLE, hi: ssr_pkg::HI_RESET, wr_d: 1'b0, dout: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // write strobe trailing edge commits; ignored while read also stands
  assign wr_commit = (s.st == SSR_ACCESS) && enable && s.wr_d && !wr_s && !rd_s;

  // nibble split; storage has no reset, contents are random at power-up
  always_ff @(posedge clk) begin
    if (wr_commit) begin
      mem_hi[index] <= din_s[7:4];
      mem_lo[index] <= din_s[3:0];
    end
  end

  // buffers float until matched, drive only on read
  assign data_oe        = (s.st == SSR_ACCESS) && enable && rd_s;
  assign data_out       = s.dout;
  assign board_selected = (s.st == SSR_ACCESS) && enable;

  chk_float_no_match: assert property (@(posedge clk) disable iff (!resetn)
    !enable |-> !data_oe) else $error("buffer driven without block match");
  chk_rnu_inhibit: assert property (@(posedge clk) disable iff (!resetn)
    (option_link_set && rnu_s) |-> !board_selected) else $error("board active during run utility");
  chk_hi_capture: assert property (@(posedge clk) disable iff (!resetn)
    (s.st == SSR_STROBE && tpa_s) |=> (s.hi == $past(lo_s))) else $error("high byte not captured");
  chk_block_match: assert property (@(posedge clk) disable iff (!resetn)
    board_selected |-> (s.hi[7:5] == block_switch_closed)) else $error("selected outside block");
  chk_read_drive: assert property (@(posedge clk) disable iff (!resetn)
    data_oe |-> rd_s) else $error("drive without read strobe");
  chk_hi_hold: assert property (@(posedge clk) disable iff (!resetn)
    (s.st == SSR_ACCESS && !tpa_s) |=> $stable(s.hi)) else $error("high byte changed mid access");
  chk_pair_sel: assert property (@(posedge clk) disable iff (!resetn)
    index[12:10] == {s.hi[4], s.hi[3:2]}) else $error("wrong pair select");
  chk_row_bits: assert property (@(posedge clk) disable iff (!resetn)
    index[9:8] == s.hi[1:0]) else $error("device row bits wrong");

  // Low byte goes straight to the devices
  chk_low_direct: assert property (@(posedge clk) disable iff (!resetn)
    index[7:0] == lo_s) else $error("low address byte not direct");

  // No write outside the switch block
  chk_write_match: assert property (@(posedge clk) disable iff (!resetn)
    wr_commit |-> match) else $error("write outside block");

  // Inhibit blocks writes as well as reads
  chk_inhibit_write: assert property (@(posedge clk) disable iff (!resetn)
    (option_link_set && rnu_s) |-> !wr_commit) else $error("write during run utility");

  // A write never commits while read stands
  chk_write_no_read: assert property (@(posedge clk) disable iff (!resetn)
    wr_commit |-> !rd_s) else $error("write commit during read");

  // Buffers drive only in the access phase
  chk_oe_access: assert property (@(posedge clk) disable iff (!resetn)
    data_oe |-> (s.st == SSR_ACCESS)) else $error("drive outside access phase");

  // Selection needs the switch compare on any connector
  chk_sel_switch: assert property (@(posedge clk) disable iff (!resetn)
    board_selected |-> match) else $error("selected without switch match");

  // Read data register only moves on a matched read
  chk_dout_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(s.st == SSR_ACCESS && enable && rd_s) |=> $stable(data_out)) else $error("read data moved");

  // Strobe starts a capture phase
  chk_strobe_enter: assert property (@(posedge clk) disable iff (!resetn)
    (s.st == SSR_IDLE && tpa_s) |=> (s.st == SSR_STROBE)) else $error("strobe not taken");

  // Strobe trailing edge ends the capture phase
  chk_strobe_leave: assert property (@(posedge clk) disable iff (!resetn)
    (s.st == SSR_STROBE && !tpa_s) |=> (s.st == SSR_ACCESS)) else $error("access not entered");
endmodule : ssr_ram_board

/* File: ssr_pkg.sv */
// Package for the switch-selected 8 KB RAM board logic.
// Assumes a single 200 MHz clock domain; no software-visible registers.
package ssr_pkg;
  localparam int   ADDR_W       = 8;       // Multiplexed address bus width
  localparam int   DATA_W       = 8;       // Data bus width
  localparam int   NIB_W        = 4;       // Width of one 1024x4 device
  localparam int   PAIRS        = 8;       // Device pairs on the board
  localparam int   WORDS        = 1024;    // Words per device
  localparam int   BLK_LSB      = 5;       // Block bits 7..5 of high byte
  localparam int   HALF_BIT     = 4;       // Picks one 4 KB half
  localparam int   PAIR_LSB     = 2;       // Pair within half, bits 3..2
  localparam int   ROW_LSB      = 0;       // Device A8/A9 from bits 1..0
  localparam int   SYNC_STAGES  = 3;       // Pin synchroniser depth
  localparam logic [7:0] HI_RESET = 8'h00; // Latched high byte at reset
endpackage : ssr_pkg

/* File: ssr_sync.sv */
// Three-stage pin synchroniser; output changes once stages two and three agree.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
module ssr_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
  } ssr_sync_t;
  ssr_sync_t s;
  ssr_sync_t next_s;

  // Stage one is read only by stage two
  always_comb begin
    next_s     = s;
    next_s.sh  = {s.sh[1:0], pin};
    if (s.sh[1] == s.sh[2]) begin
      next_s.lvl = s.sh[2];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;
endmodule : ssr_sync

/* File: ssr_bus_master.sv */
// Bus master model: multiplexed address, address strobe, read and write strobes.
// Assumes one caller at a time; every pin changes just after a rising edge.
`timescale 1ns/10ps
module ssr_bus_master (
  input  wire logic       clk,
  output logic      [7:0] addr_bus,
  output logic            address_strobe_pulse,
  output logic            memory_read_strobe_n,
  output logic            memory_write_strobe_n,
  output logic      [7:0] data_in
);
  // Idle bus; released lines show inverted data, never a stale copy
  initial begin
    addr_bus = 8'h00;
    address_strobe_pulse = 1'b0;
    memory_read_strobe_n = 1'b1;
    memory_write_strobe_n = 1'b1;
    data_in = 8'h00;
  end
  // One access; n sets how long the read or write strobe is held
  task automatic access(input logic [7:0] hi, lo, input logic wr, input logic [7:0] wd,
                        input int n);
    @(posedge clk) addr_bus <= hi;
    address_strobe_pulse <= 1'b1;
    repeat (4) @(posedge clk);
    address_strobe_pulse <= 1'b0;
    addr_bus <= lo;
    data_in <= wr ? wd : ~wd;
    repeat (4) @(posedge clk);
    if (wr) memory_write_strobe_n <= 1'b0;
    else memory_read_strobe_n <= 1'b0;
    repeat (n) @(posedge clk);
    memory_write_strobe_n <= 1'b1;
    memory_read_strobe_n <= 1'b1;
    repeat (6) @(posedge clk);
    addr_bus <= ~lo;
    data_in <= ~wd;
    repeat (2) @(posedge clk);
  endtask : access
endmodule : ssr_bus_master

/* File: ssr_ram_board_test.sv */
// Self-checking bench for the switch-selected RAM board.
// Assumes the bus master model drives every bus pin of the board.
`timescale 1ns/10ps
module ssr_ram_board_test;
  logic       clk, resetn, rur, link, ast, rd_n, wr_n, oe, sel, oe_seen;
  logic [2:0] sw;
  logic [7:0] ab, din, dout, lo, mem [8];
  logic [7:0] exp_q [$];
  int         failures = 0, total_checks = 0, cnt = 0, seed = 32'hb312;
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ssr_ram_board i_dut (.clk(clk), .resetn(resetn), .addr_bus(ab), .address_strobe_pulse(ast),
    .memory_read_strobe_n(rd_n), .memory_write_strobe_n(wr_n), .run_utility_request(rur),
    .option_link_set(link), .block_switch_closed(sw), .data_in(din), .data_out(dout),
    .data_oe(oe), .board_selected(sel));
  ssr_bus_master i_bus (.clk(clk), .addr_bus(ab), .address_strobe_pulse(ast),
    .memory_read_strobe_n(rd_n), .memory_write_strobe_n(wr_n), .data_in(din));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // Read results: data_out is settled once oe has stood two cycles
  always @(posedge clk) begin
    cnt <= (oe === 1'b1) ? cnt + 1 : 0;
    if (oe === 1'b1) oe_seen <= 1'b1;
    if (cnt == 2 && exp_q.size() == 0) check(8'h01, 8'h00);
    else if (cnt == 2) check(dout, exp_q.pop_front());
  end
  // One access, its read outcome noted first; oe must rise only on a hit read
  task automatic go(input logic [7:0] hi, input logic wr, input logic [7:0] wd, input logic hit);
    oe_seen = 1'b0;
    if (!wr && hit) exp_q.push_back(wd);
    i_bus.access(hi, lo, wr, wd, 6 + ($random(seed) & 7));
    check({6'h00, oe_seen, exp_q.size() == 0}, {6'h00, ~wr & hit, 1'b1});
  endtask : go
  initial begin
    resetn = 1'b0;
    rur = 1'b0;
    link = 1'b0;
    sw = 3'h0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    // Every switch setting: fill all eight pairs, read back, then miss
    for (int s = 0; s < 8; s++) begin
      sw <= s[2:0];
      lo = $random(seed);
      for (int k = 0; k < 8; k++) begin
        mem[k] = $random(seed);
        go({s[2:0], k[2:0], 2'b10}, 1'b1, mem[k], 1'b1);
      end
      for (int k = 0; k < 8; k++) go({s[2:0], k[2:0], 2'b10}, 1'b0, mem[k], 1'b1);
      go({s[2:0] ^ 3'h4, 5'h0A}, 1'b0, 8'h00, 1'b0);
    end
    // Inhibit: no write and no answer, then link cut lets reads through
    link <= 1'b1;
    rur <= 1'b1;
    go(8'hE2, 1'b1, ~mem[0], 1'b0);
    go(8'hE2, 1'b0, mem[0], 1'b0);
    link <= 1'b0;
    go(8'hE2, 1'b0, mem[0], 1'b1);
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule : ssr_ram_board_test
